/* File: usdp_map.svh */
/*
  Address map, field positions, reset values and sizes of the shadow
  data port. Assumes a 32-bit APB master with word-aligned accesses.
*/
// Functional notes
// - Sixteen consecutive 32-bit word aliases all reach the same data path.
// - Alias read returns received byte in bits 7:0, serial or infrared source.
// - Read data is meaningful only while the byte-available flag is set.
// - FIFOs off: new byte overwrites unread byte and raises overrun.
// - FIFOs on: alias read returns and consumes receive FIFO head.
// - Receive FIFO full: keep contents, drop new byte, raise overrun.
// - Alias write queues low byte for serial or infrared transmit.
// - FIFOs off: one write clears the transmit-holding-empty flag.
// - FIFOs off: further writes replace the pending transmit byte.
// - FIFOs on: depth writes (default 16) accepted before FIFO full.
// - Write while transmit FIFO full is dropped, contents unchanged.
`ifndef USDP_MAP_SVH
`define USDP_MAP_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define USDP_ADDR_WORD_11     32'h5000115c
`define USDP_ADDR_WORD_12     32'h50001160
`define USDP_ALIAS_WORDS      16
`define USDP_ALIAS_BASE       (`USDP_ADDR_WORD_11 - 32'h0000002c)
`define USDP_ALIAS_SPAN       32'h00000040
`define USDP_ADDR_CTRL        32'h50001170
`define USDP_ADDR_LINE        32'h50001174
`define USDP_ADDR_IRQ_STAT    32'h50001178
`define USDP_ADDR_IRQ_MASK    32'h5000117c

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define USDP_CTRL_FIFO_EN     0
`define USDP_CTRL_IR_MODE     1
`define USDP_LINE_RX_AVAIL    0
`define USDP_LINE_OVERRUN     1
`define USDP_LINE_TX_EMPTY    5
`define USDP_IRQ_RX_AVAIL     0
`define USDP_IRQ_OVERRUN      1
`define USDP_IRQ_TX_EMPTY     2
`define USDP_IRQ_BITS         3
`define USDP_IRQ_RESET        3'h0
`define USDP_FIFO_DEPTH       16
`define USDP_DATA_RESET       8'h00

`endif

/* File: usdp_pkg.sv */
/*
  Types shared by the shadow data port modules.
  Assumes usdp_map.svh is on the include path.
*/
package usdp_pkg;

  typedef logic [7:0] usdp_byte_t;

  typedef enum logic [1:0] {
    USDP_APB_IDLE   = 2'b01,
    USDP_APB_ANSWER = 2'b10
  } usdp_apb_e;

endpackage : usdp_pkg

/* File: usdp_fifo_if.sv */
/*
  Connection between the port logic and one byte store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface usdp_fifo_if;
  import usdp_pkg::*;

  logic       push;
  logic       pop;
  logic       flush;
  logic       single;
  usdp_byte_t wdata;
  usdp_byte_t rdata;
  logic       full;
  logic       empty;

  modport owner (output push, pop, flush, single, wdata,
                 input  rdata, full, empty);
  modport store (input  push, pop, flush, single, wdata,
                 output rdata, full, empty);
endinterface : usdp_fifo_if

/* File: usdp_fifo.sv */
/*
  Byte store that acts as a FIFO of DEPTH entries, or as a single
  holding register whose unread byte a new push replaces.
  Assumes push and pop are same-clock strobes.
*/
`timescale 1ns/1ps
`include "usdp_map.svh"

module usdp_fifo
  import usdp_pkg::*;
#(
  parameter int DEPTH = `USDP_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  input  wire logic   ce_in,
  // Store side
  usdp_fifo_if.store  f
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_C  = AW'(DEPTH - 1);

  usdp_byte_t      mem_reg [DEPTH];
  usdp_byte_t      mem_next [DEPTH];
  logic [AW-1:0]   rd_reg, rd_next;
  logic [AW-1:0]   wr_reg, wr_next;
  logic [CW-1:0]   cnt_reg, cnt_next;
  logic            do_pop;
  logic            do_push;
  logic            do_over;

  assign f.empty = (cnt_reg == '0);
  assign f.full  = f.single ? (cnt_reg != '0) : (cnt_reg == DEPTH_C);
  assign f.rdata = mem_reg[rd_reg];

  always_comb begin
    do_pop   = f.pop & ~f.empty;
    // Full store takes a push only when a pop frees room this cycle
    do_push  = f.push & (~f.full | do_pop);
    // Holding mode: unread byte is replaced in place
    do_over  = f.push & f.single & f.full & ~do_pop;
    mem_next = mem_reg;
    rd_next  = rd_reg;
    wr_next  = wr_reg;
    cnt_next = cnt_reg;
    if (do_over) begin
      mem_next[rd_reg] = f.wdata;
    end
    if (do_push) begin
      mem_next[wr_reg] = f.wdata;
      wr_next = (wr_reg == LAST_C) ? '0 : wr_reg + AW'(1);
    end
    if (do_pop) begin
      rd_next = (rd_reg == LAST_C) ? '0 : rd_reg + AW'(1);
    end
    cnt_next = cnt_reg + CW'(do_push) - CW'(do_pop);
    if (f.flush) begin
      rd_next  = '0;
      wr_next  = '0;
      cnt_next = '0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= `USDP_DATA_RESET;
      end
      rd_reg  <= '0;
      wr_reg  <= '0;
      cnt_reg <= '0;
    end else if (ce_in) begin
      mem_reg <= mem_next;
      rd_reg  <= rd_next;
      wr_reg  <= wr_next;
      cnt_reg <= cnt_next;
    end
  end

endmodule : usdp_fifo

/* File: usdp_top.sv */
/*
  Shadow data port of a serial port: APB slave with sixteen aliased
  data words, receive and transmit byte stores, line state, control
  and interrupt registers.
  Assumes the serialisers sit outside on the same clock: received
  bytes arrive as one-cycle strobes, transmit bytes leave by
  valid/ready.
*/
`timescale 1ns/1ps
`include "usdp_map.svh"

module usdp_top
  import usdp_pkg::*;
#(
  parameter int RX_DEPTH = `USDP_FIFO_DEPTH,
  parameter int TX_DEPTH = `USDP_FIFO_DEPTH
) (
  // Clock, reset, enable
  input  wire logic        core_clk_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [31:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Received bytes from the line deserialisers
  input  wire logic        rx_serial_valid_in,
  input  wire usdp_byte_t  rx_serial_data_in,
  input  wire logic        rx_ir_valid_in,
  input  wire usdp_byte_t  rx_ir_data_in,
  // Transmit bytes to the line serialisers
  output logic             tx_serial_valid_out,
  output logic             tx_ir_valid_out,
  output usdp_byte_t       tx_data_out,
  input  wire logic        tx_ready_in,
  // Mode and interrupt
  output logic             fifo_enable_out,
  output logic             ir_mode_out,
  output logic             irq_out
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic is_alias(input logic [31:0] a);
    logic [31:0] off;
    off = a - `USDP_ALIAS_BASE;
    // One offset covers every alias word, so bursts stay on one path
    return (a >= `USDP_ALIAS_BASE) && (off < `USDP_ALIAS_SPAN);
  endfunction : is_alias

  function automatic logic is_mapped(input logic [31:0] a);
    return is_alias(a) || (a == `USDP_ADDR_CTRL) ||
           (a == `USDP_ADDR_LINE) || (a == `USDP_ADDR_IRQ_STAT) ||
           (a == `USDP_ADDR_IRQ_MASK);
  endfunction : is_mapped

  // ****************************************************************
  // Declarations
  // ****************************************************************
  usdp_fifo_if rx_f ();
  usdp_fifo_if tx_f ();

  usdp_apb_e                   state_reg, state_next;
  logic [31:0]                 prdata_reg, prdata_next;
  logic                        fifo_en_reg, fifo_en_next;
  logic                        ir_mode_reg, ir_mode_next;
  logic                        overrun_reg, overrun_next;
  logic                        tx_empty_d_reg, tx_empty_d_next;
  logic [`USDP_IRQ_BITS-1:0]   irq_stat_reg, irq_stat_next;
  logic [`USDP_IRQ_BITS-1:0]   irq_mask_reg, irq_mask_next;
  logic [`USDP_IRQ_BITS-1:0]   irq_event;
  logic [31:0]                 rd_word;
  logic                        xfer;
  logic                        wr_done;
  logic                        rd_done;
  logic                        lane0;
  logic                        rx_push;
  usdp_byte_t                  rx_byte;
  logic                        overrun_evt;
  logic                        flush;
  // Register selects, at most one high at a time
  logic                        sel_alias;
  logic                        sel_ctrl;
  logic                        sel_line;
  logic                        sel_stat;
  logic                        sel_mask;

  // ****************************************************************
  // Register select
  // ****************************************************************
  // Decoded once so every path agrees on which word is addressed
  assign sel_alias = is_alias(paddr_in);
  assign sel_ctrl  = (paddr_in == `USDP_ADDR_CTRL);
  assign sel_line  = (paddr_in == `USDP_ADDR_LINE);
  assign sel_stat  = (paddr_in == `USDP_ADDR_IRQ_STAT);
  assign sel_mask  = (paddr_in == `USDP_ADDR_IRQ_MASK);

  // ****************************************************************
  // Byte stores
  // ****************************************************************
  usdp_fifo #(
    .DEPTH  (RX_DEPTH)
  ) u_rx_store (
    .clk_in (core_clk_in),
    .rst_in (reset_in),
    .ce_in  (clk_en_in),
    .f      (rx_f.store)
  );

  usdp_fifo #(
    .DEPTH  (TX_DEPTH)
  ) u_tx_store (
    .clk_in (core_clk_in),
    .rst_in (reset_in),
    .ce_in  (clk_en_in),
    .f      (tx_f.store)
  );

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One answer cycle after setup; frozen enable holds the answer off
  assign pready_out  = (state_reg == USDP_APB_ANSWER) & clk_en_in;
  assign xfer        = psel_in & penable_in & pready_out;
  assign wr_done     = xfer & pwrite_in;
  assign rd_done     = xfer & ~pwrite_in;
  assign pslverr_out = pready_out & ~is_mapped(paddr_in);
  assign prdata_out  = prdata_reg;
  assign lane0       = pstrb_in[0];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      USDP_APB_IDLE: begin
        if (psel_in & ~penable_in) begin
          state_next = USDP_APB_ANSWER;
        end
      end
      USDP_APB_ANSWER: begin
        if (xfer) begin
          state_next = USDP_APB_IDLE;
        end
      end
      default: begin
        state_next = USDP_APB_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Read data, captured in the setup cycle
  // ****************************************************************
  always_comb begin
    rd_word = '0;
    if (sel_alias) begin
      // Upper byte and above read zero; head is meaningful only
      // while the byte-available flag is set
      rd_word[7:0] = rx_f.empty ? `USDP_DATA_RESET :
                                  rx_f.rdata;
    end else if (sel_ctrl) begin
      rd_word[`USDP_CTRL_FIFO_EN] = fifo_en_reg;
      rd_word[`USDP_CTRL_IR_MODE] = ir_mode_reg;
    end else if (sel_line) begin
      rd_word[`USDP_LINE_RX_AVAIL] = ~rx_f.empty;
      rd_word[`USDP_LINE_OVERRUN]  = overrun_reg;
      rd_word[`USDP_LINE_TX_EMPTY] = tx_f.empty;
    end else if (sel_stat) begin
      rd_word[`USDP_IRQ_BITS-1:0] = irq_stat_reg;
    end else if (sel_mask) begin
      rd_word[`USDP_IRQ_BITS-1:0] = irq_mask_reg;
    end
    // Capture at setup keeps the decode out of the answer cycle
    prdata_next = prdata_reg;
    if ((state_reg == USDP_APB_IDLE) & psel_in & ~penable_in &
        ~pwrite_in) begin
      prdata_next = rd_word;
    end
  end

  // ****************************************************************
  // Receive path
  // ****************************************************************
  // Only the selected line feeds the store; the other is ignored
  always_comb begin
    rx_push = ir_mode_reg ? rx_ir_valid_in : rx_serial_valid_in;
    rx_byte = ir_mode_reg ? rx_ir_data_in  : rx_serial_data_in;
  end

  assign rx_f.push   = rx_push;
  assign rx_f.wdata  = rx_byte;
  // Holding mode when FIFOs are off
  assign rx_f.single = ~fifo_en_reg;
  // Any alias read consumes the head in either mode
  assign rx_f.pop    = rd_done & sel_alias;
  assign rx_f.flush  = flush;
  // Full store and no pop: holding mode overwrites, FIFO mode drops
  assign overrun_evt = rx_push & rx_f.full & ~rx_f.pop;

  // ****************************************************************
  // Transmit path
  // ****************************************************************
  // Only the low lane carries the byte; bits 31:8 are dropped
  assign tx_f.push   = wr_done & sel_alias & lane0;
  assign tx_f.wdata  = pwdata_in[7:0];
  // Holding mode replaces a pending byte; FIFO mode drops when full
  assign tx_f.single = ~fifo_en_reg;
  // Head leaves only on valid and ready; a frozen enable holds it
  assign tx_f.pop    = tx_ready_in & ~tx_f.empty & clk_en_in;
  assign tx_f.flush  = flush;
  assign tx_data_out = tx_f.rdata;

  always_comb begin
    tx_serial_valid_out = ~tx_f.empty & ~ir_mode_reg;
    tx_ir_valid_out     = ~tx_f.empty &  ir_mode_reg;
  end

  // ****************************************************************
  // Control, line state and interrupts
  // ****************************************************************
  // Switching FIFO mode empties both stores so no stale byte leaks
  assign flush = wr_done & lane0 & sel_ctrl &
                 (pwdata_in[`USDP_CTRL_FIFO_EN] != fifo_en_reg);

  always_comb begin
    irq_event = '0;
    irq_event[`USDP_IRQ_RX_AVAIL] = rx_push & ~rx_f.full;
    irq_event[`USDP_IRQ_OVERRUN]  = overrun_evt;
    irq_event[`USDP_IRQ_TX_EMPTY] = tx_f.empty & ~tx_empty_d_reg;
  end

  always_comb begin
    fifo_en_next    = fifo_en_reg;
    ir_mode_next    = ir_mode_reg;
    irq_mask_next   = irq_mask_reg;
    irq_stat_next   = irq_stat_reg;
    overrun_next    = overrun_reg;
    tx_empty_d_next = tx_f.empty;
    if (wr_done & lane0) begin
      if (sel_ctrl) begin
        fifo_en_next = pwdata_in[`USDP_CTRL_FIFO_EN];
        ir_mode_next = pwdata_in[`USDP_CTRL_IR_MODE];
      end
      if (sel_mask) begin
        irq_mask_next = pwdata_in[`USDP_IRQ_BITS-1:0];
      end
      if (sel_stat) begin
        irq_stat_next = irq_stat_reg & ~pwdata_in[`USDP_IRQ_BITS-1:0];
      end
    end
    // Overrun flag clears when line state is read
    if (rd_done & sel_line) begin
      overrun_next = 1'b0;
    end
    // New events win over a clear in the same cycle
    irq_stat_next = irq_stat_next | irq_event;
    if (overrun_evt) begin
      overrun_next = 1'b1;
    end
  end

  // Level output: stays up until software clears or masks the cause
  assign irq_out         = |(irq_stat_reg & irq_mask_reg);
  assign fifo_enable_out = fifo_en_reg;
  assign ir_mode_out     = ir_mode_reg;

  // ****************************************************************
  // State registers
  // ****************************************************************
  // Bus handshake and read capture
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg      <= USDP_APB_IDLE;
      prdata_reg     <= '0;
    end else if (clk_en_in) begin
      state_reg      <= state_next;
      prdata_reg     <= prdata_next;
    end
  end

  // Mode, line state and interrupt flags
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      fifo_en_reg    <= 1'b0;
      ir_mode_reg    <= 1'b0;
      overrun_reg    <= 1'b0;
      tx_empty_d_reg <= 1'b1;
      irq_stat_reg   <= `USDP_IRQ_RESET;
      irq_mask_reg   <= `USDP_IRQ_RESET;
    end else if (clk_en_in) begin
      fifo_en_reg    <= fifo_en_next;
      ir_mode_reg    <= ir_mode_next;
      overrun_reg    <= overrun_next;
      tx_empty_d_reg <= tx_empty_d_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
    end
  end

endmodule : usdp_top

/* File: usdp_chk.sv */
/*
  Checker for the shadow data port top ports.
  Assumes it is bound to usdp_top and sees its ports only.
*/
`timescale 1ns/1ps
`include "usdp_map.svh"

module usdp_chk
  import usdp_pkg::*;
(
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        reset_in,
  input wire logic        clk_en_in,
  // APB
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Transmit, mode, interrupt
  input wire logic        tx_serial_valid_out,
  input wire logic        tx_ir_valid_out,
  input wire usdp_byte_t  tx_data_out,
  input wire logic        tx_ready_in,
  input wire logic        fifo_enable_out,
  input wire logic        ir_mode_out,
  input wire logic        irq_out
);
  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic done;
  logic al;
  logic txv;
  assign done = psel_in & penable_in & pready_out;
  assign al = paddr_in >= `USDP_ALIAS_BASE &&
              paddr_in < `USDP_ALIAS_BASE + `USDP_ALIAS_SPAN;
  assign txv = tx_serial_valid_out | tx_ir_valid_out;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  a_ready_after_setup: assert property (
    psel_in && !penable_in && clk_en_in |=> pready_out)
    else $error("no ready after setup");
  a_ready_in_access: assert property (
    pready_out |-> psel_in && penable_in)
    else $error("ready outside access");
  a_err_unmapped: assert property (
    pslverr_out |-> pready_out && !al)
    else $error("error on mapped word");
  a_alias_no_err: assert property (
    done && al |-> !pslverr_out)
    else $error("alias word refused");
  a_upper_zero: assert property (
    done && al && !pwrite_in |-> prdata_out[31:8] == 24'h000000)
    else $error("alias upper bits set");
  a_line_select: assert property (
    txv |-> tx_ir_valid_out == ir_mode_out &&
            tx_serial_valid_out != ir_mode_out)
    else $error("wrong transmit line");
  a_tx_replace: assert property (
    done && al && pwrite_in && pstrb_in[0] && !fifo_enable_out &&
    !tx_ready_in |=> txv && tx_data_out == $past(pwdata_in[7:0]))
    else $error("write not pending");
  a_tx_stall_hold: assert property (
    txv && !tx_ready_in && !(done && pwrite_in) |=>
    txv && $stable(tx_data_out))
    else $error("head moved while stalled");
  a_mode_hold: assert property (
    !(done && pwrite_in && paddr_in == `USDP_ADDR_CTRL) |=>
    $stable(fifo_enable_out) && $stable(ir_mode_out))
    else $error("mode changed alone");

  c_alias_read: cover property (done && al && !pwrite_in);
  c_refused: cover property (done && pslverr_out);
  c_irq: cover property (irq_out);
endmodule : usdp_chk

/* File: usdp_peer.sv */
/*
  Line peer: hands received bytes to the port and takes transmit
  bytes, promptly or with a stall. Assumes the port's clock.
*/
`timescale 1ns/1ps

module usdp_peer
  import usdp_pkg::*;
(
  // Clock
  input  wire logic       clk_in,
  // Bytes towards the port
  output logic            ser_v_out,
  output usdp_byte_t      ser_d_out,
  output logic            ir_v_out,
  output usdp_byte_t      ir_d_out,
  // Bytes from the port
  input  wire logic       s_v_in,
  input  wire logic       i_v_in,
  input  wire usdp_byte_t d_in,
  output logic            rdy_out
);
  logic       stall;
  logic [8:0] q[$];

  initial begin
    ser_v_out = 1'b0;
    ir_v_out = 1'b0;
    ser_d_out = 8'h00;
    ir_d_out = 8'hff;
    stall = 1'b0;
  end
  assign rdy_out = !stall;

  // Data lines show the inverse once the strobe is gone
  task automatic send(input logic ir, input usdp_byte_t b);
    @(posedge clk_in);
    ser_v_out <= !ir;
    ir_v_out <= ir;
    ser_d_out <= b;
    ir_d_out <= b;
    @(posedge clk_in);
    ser_v_out <= 1'b0;
    ir_v_out <= 1'b0;
    ser_d_out <= ~b;
    ir_d_out <= ~b;
  endtask : send

  always @(posedge clk_in) begin
    if (rdy_out && (s_v_in || i_v_in))
      q.push_back({i_v_in, d_in});
  end
endmodule : usdp_peer

/* File: test_uart_shadow_data_port.sv */
/*
  Self-checking bench for the shadow data port.
  Assumes usdp_chk and usdp_peer are compiled first.
*/
`timescale 1ns/1ps
`include "usdp_map.svh"

module test_uart_shadow_data_port
  import usdp_pkg::*;
;
  localparam int D = 4;
  localparam logic [31:0] AL = `USDP_ALIAS_BASE;
  localparam logic [31:0] LN = `USDP_ADDR_LINE;
  localparam logic [31:0] CT = `USDP_ADDR_CTRL;
  localparam logic [31:0] IS = `USDP_ADDR_IRQ_STAT;
  localparam logic [31:0] IM = `USDP_ADDR_IRQ_MASK;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [31:0] pa;
  logic [31:0] pwd;
  logic [31:0] prd;
  logic        pready;
  logic        perr;
  logic        txs;
  logic        txi;
  logic        fen;
  logic        irm;
  logic        irq;
  logic        rsv;
  logic        riv;
  logic        trdy;
  usdp_byte_t  txd;
  usdp_byte_t  rsd;
  usdp_byte_t  rid;
  int          err_total;
  int          n_tests;

  usdp_top #(.RX_DEPTH(D), .TX_DEPTH(D)) i_dut (
    .core_clk_in(clk), .reset_in(rst), .clk_en_in(1'b1),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
    .paddr_in(pa), .pwdata_in(pwd), .pstrb_in(4'hf),
    .prdata_out(prd), .pready_out(pready), .pslverr_out(perr),
    .rx_serial_valid_in(rsv), .rx_serial_data_in(rsd),
    .rx_ir_valid_in(riv), .rx_ir_data_in(rid),
    .tx_serial_valid_out(txs), .tx_ir_valid_out(txi),
    .tx_data_out(txd), .tx_ready_in(trdy),
    .fifo_enable_out(fen), .ir_mode_out(irm), .irq_out(irq));

  usdp_peer i_peer (.clk_in(clk), .ser_v_out(rsv), .ser_d_out(rsd),
    .ir_v_out(riv), .ir_d_out(rid), .s_v_in(txs), .i_v_in(txi),
    .d_in(txd), .rdy_out(trdy));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic results();
    $display("Mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("Error at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk

  task automatic stop(input string s);
    err_total++;
    $display("Error at %0t: %s timed out", $time, s);
    results();
  endtask : stop

  task automatic apb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      stop("bus");
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h00000000, r, e);
    chk(r, x);
  endtask : rd

  // Bounded wait for the peer to collect n bytes
  task automatic wq(input int n);
    int k;
    for (k = 0; k < 60 && i_peer.q.size() < n; k++)
      @(posedge clk);
    if (i_peer.q.size() < n)
      stop("peer");
  endtask : wq

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rd(LN, 32'h00000020);
    rd(CT, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
  endtask : t_reset

  task automatic t_hold_rx();
    i_peer.send(1'b0, 8'ha5);
    rd(LN, 32'h00000021);
    i_peer.send(1'b0, 8'h3c);
    rd(LN, 32'h00000023);
    rd(AL + 32'h2c, 32'h0000003c);
    rd(LN, 32'h00000020);
  endtask : t_hold_rx

  task automatic t_ir_rx();
    wr(CT, 32'h00000002);
    i_peer.send(1'b0, 8'h11);
    i_peer.send(1'b1, 8'h5a);
    chk({30'h0, fen, irm}, 32'h00000001);
    rd(LN, 32'h00000021);
    rd(AL + 32'h30, 32'h0000005a);
  endtask : t_ir_rx

  task automatic t_fifo_rx();
    wr(CT, 32'h00000001);
    for (int i = 0; i <= D; i++)
      i_peer.send(1'b0, usdp_byte_t'(8'h10 + i));
    chk({30'h0, fen, irm}, 32'h00000002);
    rd(LN, 32'h00000023);
    for (int i = 0; i < D; i++)
      rd(AL + 32'(4 * i), 32'h10 + 32'(i));
    rd(LN, 32'h00000020);
  endtask : t_fifo_rx

  task automatic t_tx_hold();
    wr(CT, 32'h00000000);
    i_peer.stall <= 1'b1;
    wr(AL, 32'hffff55a1);
    rd(LN, 32'h00000000);
    wr(AL + 32'h3c, 32'h0000ffb2);
    i_peer.stall <= 1'b0;
    wq(1);
    rd(LN, 32'h00000020);
    chk(32'(i_peer.q.size()), 32'h00000001);
    chk({23'h0, i_peer.q.pop_front()}, 32'h000000b2);
  endtask : t_tx_hold

  task automatic t_tx_fifo();
    wr(CT, 32'h00000003);
    i_peer.stall <= 1'b1;
    for (int i = 0; i <= D; i++)
      wr(AL + 32'(4 * i), 32'hc0 + 32'(i));
    rd(LN, 32'h00000000);
    i_peer.stall <= 1'b0;
    wq(D);
    rd(LN, 32'h00000020);
    chk(32'(i_peer.q.size()), 32'(D));
    for (int i = 0; i < D; i++)
      chk({23'h0, i_peer.q.pop_front()}, 32'h1c0 + 32'(i));
  endtask : t_tx_fifo

  task automatic t_irq();
    wr(CT, 32'h00000000);
    wr(IS, 32'h00000007);
    i_peer.send(1'b0, 8'h01);
    i_peer.send(1'b0, 8'h02);
    chk({31'h0, irq}, 32'h00000000);
    wr(IM, 32'h00000002);
    @(posedge clk);
    chk({31'h0, irq}, 32'h00000001);
    wr(IS, 32'h00000002);
    @(posedge clk);
    chk({31'h0, irq}, 32'h00000000);
    rd(AL, 32'h00000002);
  endtask : t_irq

  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 32'h50001180, 32'h00000000, r, e);
    chk({31'h0, e}, 32'h00000001);
    chk(r, 32'h00000000);
    wr(LN, 32'h00000000);
    // Overrun left by the interrupt scenario survives the ignored write
    rd(LN, 32'h00000022);
    rd(LN, 32'h00000020);
  endtask : t_unmapped

  // ****************************************************************
  // Clock and main sequence
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    pa = 32'h00000000;
    pwd = 32'h00000000;
    err_total = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_hold_rx();
    t_ir_rx();
    t_fifo_rx();
    t_tx_hold();
    t_tx_fifo();
    t_irq();
    t_unmapped();
    results();
  end
endmodule : test_uart_shadow_data_port

bind usdp_top usdp_chk i_chk (.core_clk_in, .reset_in, .clk_en_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
  .prdata_out, .pready_out, .pslverr_out, .tx_serial_valid_out,
  .tx_ir_valid_out, .tx_data_out, .tx_ready_in, .fifo_enable_out,
  .ir_mode_out, .irq_out);
